// [rtl/ats_top.sv]
// Absolute time keeping: 1 Hz tick, GPS or PTP discipline, packet and firing times.
// Assumes all inputs synchronous to pclk; the PTP engine and NMEA parser sit outside.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps

// Operation
// R1 - Select GPS or PTP by control bit
// R2 - Accept configured RMC or GGA sentence
// R3 - GPS packet strobe on each tick
// R4 - Unlocked: count seconds from virtual start
// R5 - Locked: load sentence time plus one
// R6 - Gate sync on PPS lock if enabled
// R7 - NMEA lost: keep counting, drifting
// R8 - PPS locked: align tick to PPS
// R9 - PPS unlocked or lost: tick free-runs
// R10 - PTP mode suppresses GPS packets
// R11 - PTP free-run counts from virtual start
// R12 - PTP tracking/locked loads master time
// R13 - PTP frozen keeps counting, drifting
// R14 - Packet time is seconds plus microseconds
// R15 - Single return: block start 5.632 minus 50us steps
// R16 - Dual return: pairs share start time
// R17 - Channels fire one to sixteen ascending
// R18 - Channel offset 3.024*(n-1)+0.368 us
// R19 - Firing time is block start plus offset
// R20 - Microseconds restart on each tick
module ats_top #(
	parameter int TICK_CYC = ats_pkg::TICK_CYC_DEF,
	parameter int PPS_LOSS_CYC = ats_pkg::PPS_LOSS_CYC_DEF,
	parameter int NMEA_LOSS_CYC = ats_pkg::NMEA_LOSS_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pps_in,
	input wire ats_pkg::ats_nmea_s nmea,
	input wire ats_pkg::ats_ptp_s ptp,
	input wire logic pkt_mark,
	input wire logic round_go,
	input wire logic [2:0] round_blk,
	output logic tick_pulse,
	output logic gps_pkt_stb,
	output ats_pkg::ats_time_s time_now,
	output ats_pkg::ats_time_s packet_abs_time,
	output ats_pkg::ats_fire_s fire
);
	import ats_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_SEC) ||
			(a == OFS_USEC) || (a == OFS_PKT_SEC) || (a == OFS_PKT_USEC);
	endfunction

	function automatic logic is_locked(input ats_lock_e st);
		is_locked = (st == LK_LOCKED);
	endfunction

	function automatic logic tracks_master(input ats_ptp_e st);
		tracks_master = (st == PTP_TRACKING) || (st == PTP_LOCKED);
	endfunction

	// R18 channel offset
	function automatic logic [15:0] chan_ofs_ns(input logic [3:0] ch);
		logic [19:0] prod;
		prod = 20'(ch) * 20'(CH_STEP_NS);
		chan_ofs_ns = prod[15:0] + CH_BASE_NS;
	endfunction

	function automatic logic signed [31:0] blk_start_ns(input logic [2:0] blk, input logic dual);
		logic [2:0] steps;
		steps = BLK_LAST - blk;
		// R16 pairs share start
		if (dual) begin
			steps = steps >> 1;
		end
		// R15 block start step
		blk_start_ns = BLK_BASE_NS - BLK_STEP_NS * $signed({29'h0, steps});
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	ats_ctrl_s ctrl, next_ctrl;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic pps_d;
	logic pps_rise;
	ats_lock_e pps_state, next_pps_state;
	ats_lock_e nmea_state, next_nmea_state;
	logic [31:0] pps_wd, next_pps_wd;
	logic [31:0] nmea_wd, next_nmea_wd;
	logic [31:0] nmea_hold, next_nmea_hold;
	logic nmea_ok;
	logic [31:0] tick_cnt, next_tick_cnt;
	logic [7:0] us_div, next_us_div;
	logic tick_now;
	logic tick_expire, pps_align, gps_sync_ok, us_wrap;
	logic apb_access, apb_commit, chan_due;
	logic ptp_sync_load;
	logic synced, next_synced;
	ats_time_s next_time_now;
	ats_time_s next_packet_abs_time;
	logic next_tick_pulse, next_gps_pkt_stb;
	logic seq_act, next_seq_act;
	logic [2:0] seq_blk, next_seq_blk;
	logic [3:0] seq_ch, next_seq_ch;
	logic [15:0] seq_ns, next_seq_ns;
	ats_fire_s next_fire;

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, error on unmapped address

	assign apb_access = psel && penable && !pready;
	assign apb_commit = psel && penable && pready;

	always_comb begin
		next_ctrl = ctrl;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		if (apb_access) begin
			next_pready = 1'b1;
			next_pslverr = !addr_known(paddr);
			next_prdata = 32'h0;
			if (!pwrite) begin
				case (paddr)
					OFS_CTRL: next_prdata = {28'h0, ctrl};
					OFS_STATUS: begin
						next_prdata[ST_NMEA_LSB +: 2] = nmea_state;
						next_prdata[ST_PPS_LSB +: 2] = pps_state;
						next_prdata[ST_PTP_LSB +: 2] = ptp.state;
						next_prdata[ST_SYNC_BIT] = synced;
						next_prdata[ST_TICK_BIT] = tick_pulse;
					end
					OFS_SEC: next_prdata = time_now.sec;
					OFS_USEC: next_prdata = {12'h0, time_now.usec};
					OFS_PKT_SEC: next_prdata = packet_abs_time.sec;
					OFS_PKT_USEC: next_prdata = {12'h0, packet_abs_time.usec};
					default: next_prdata = 32'h0;
				endcase
			end
		end
		// R1 source select write
		if (apb_commit && pwrite && (paddr == OFS_CTRL)) begin
			next_ctrl = ats_ctrl_s'(pwdata[CTRL_W-1:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= ats_ctrl_s'(CTRL_RESET);
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			ctrl <= next_ctrl;
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// PPS and NMEA lock tracking

	assign pps_rise = pps_in && !pps_d;
	// R2 sentence type filter
	assign nmea_ok = nmea.stb && nmea.fix && (nmea.gga == ctrl.sentence_gga);

	always_comb begin
		next_pps_state = pps_state;
		next_pps_wd = pps_wd;
		if (pps_rise) begin
			next_pps_state = LK_LOCKED;
			next_pps_wd = 32'h0;
		end else if (is_locked(pps_state)) begin
			if (pps_wd >= 32'(PPS_LOSS_CYC - 1)) begin
				next_pps_state = LK_LOST;
			end else begin
				next_pps_wd = pps_wd + 32'h1;
			end
		end
		next_nmea_state = nmea_state;
		next_nmea_wd = nmea_wd;
		next_nmea_hold = nmea_hold;
		if (nmea_ok) begin
			next_nmea_state = LK_LOCKED;
			next_nmea_wd = 32'h0;
			next_nmea_hold = nmea.sec;
		end else if (is_locked(nmea_state)) begin
			if (nmea_wd >= 32'(NMEA_LOSS_CYC - 1)) begin
				next_nmea_state = LK_LOST;
			end else begin
				next_nmea_wd = nmea_wd + 32'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pps_d <= 1'b0;
			pps_state <= LK_UNLOCKED;
			pps_wd <= 32'h0;
			nmea_state <= LK_UNLOCKED;
			nmea_wd <= 32'h0;
			nmea_hold <= EPOCH_SEC;
		end else begin
			pps_d <= pps_in;
			pps_state <= next_pps_state;
			pps_wd <= next_pps_wd;
			nmea_state <= next_nmea_state;
			nmea_wd <= next_nmea_wd;
			nmea_hold <= next_nmea_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Internal 1 Hz tick, seconds and microseconds

	// R12 master time load
	assign ptp_sync_load = ctrl.src_ptp && ptp.load && tracks_master(ptp.state);
	// R8 align tick to PPS
	assign pps_align = !ctrl.src_ptp && is_locked(pps_state) && pps_rise;
	// R9 free-run otherwise
	assign tick_expire = tick_cnt >= 32'(TICK_CYC - 1);
	assign tick_now = !ptp_sync_load && (pps_align || tick_expire);
	assign us_wrap = us_div >= 8'(CYC_PER_US - 1);
	// R6 sync gated on PPS lock
	assign gps_sync_ok = is_locked(nmea_state) &&
		(!ctrl.pulse_lock_gate || is_locked(pps_state));

	always_comb begin
		next_tick_cnt = tick_cnt + 32'h1;
		next_us_div = us_div + 8'h1;
		next_time_now = time_now;
		next_synced = synced;
		if (us_wrap) begin
			next_us_div = 8'h0;
			if (time_now.usec < USEC_MAX) begin
				next_time_now.usec = time_now.usec + 20'h1;
			end
		end
		if (ptp_sync_load) begin
			next_time_now.sec = ptp.sec;
			next_time_now.usec = ptp.usec;
			next_us_div = 8'h0;
			next_tick_cnt = 32'(ptp.usec) * 32'(CYC_PER_US);
			next_synced = 1'b1;
		end else if (tick_now) begin
			next_tick_cnt = 32'h0;
			// R20 microsecond restart
			next_us_div = 8'h0;
			next_time_now.usec = 20'h0;
			if (ctrl.src_ptp) begin
				// R11 free-run count
				// R13 frozen drift
				next_time_now.sec = time_now.sec + 32'h1;
				next_synced = synced && (ptp.state != PTP_FREE_RUN);
			end else if (gps_sync_ok) begin
				// R5 sentence time plus one
				next_time_now.sec = nmea_hold + 32'h1;
				next_synced = 1'b1;
			end else begin
				// R4 virtual count
				// R7 lost drift
				next_time_now.sec = time_now.sec + 32'h1;
				next_synced = (nmea_state == LK_LOST) && synced;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 32'h0;
			us_div <= 8'h0;
			time_now <= '{sec: EPOCH_SEC, usec: 20'h0};
			synced <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			us_div <= next_us_div;
			time_now <= next_time_now;
			synced <= next_synced;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tick, GPS packet strobe and packet time capture

	always_comb begin
		next_tick_pulse = tick_now;
		// R3 packet per tick
		// R10 none in PTP mode
		next_gps_pkt_stb = tick_now && !ctrl.src_ptp;
		next_packet_abs_time = packet_abs_time;
		// R14 seconds plus microseconds
		if (pkt_mark) begin
			next_packet_abs_time = time_now;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_pulse <= 1'b0;
			gps_pkt_stb <= 1'b0;
			packet_abs_time <= '{sec: EPOCH_SEC, usec: 20'h0};
		end else begin
			tick_pulse <= next_tick_pulse;
			gps_pkt_stb <= next_gps_pkt_stb;
			packet_abs_time <= next_packet_abs_time;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Firing round sequencer

	assign chan_due = seq_ns >= chan_ofs_ns(seq_ch);

	always_comb begin
		next_seq_act = seq_act;
		next_seq_blk = seq_blk;
		next_seq_ch = seq_ch;
		next_seq_ns = seq_ns;
		next_fire = fire;
		next_fire.stb = 1'b0;
		if (round_go && !seq_act) begin
			next_seq_act = 1'b1;
			next_seq_blk = round_blk;
			next_seq_ch = 4'h0;
			next_seq_ns = 16'h0;
		end else if (seq_act) begin
			next_seq_ns = seq_ns + 16'(CLK_NS);
			// R17 ascending channel order
			if (chan_due) begin
				next_fire.stb = 1'b1;
				next_fire.blk = seq_blk;
				next_fire.chan = seq_ch;
				// R19 block start plus offset
				next_fire.ofs_ns = blk_start_ns(seq_blk, ctrl.dual_return) +
					$signed({16'h0, chan_ofs_ns(seq_ch)});
				if (seq_ch == CH_LAST) begin
					next_seq_act = 1'b0;
				end else begin
					next_seq_ch = seq_ch + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_act <= 1'b0;
			seq_blk <= 3'h0;
			seq_ch <= 4'h0;
			seq_ns <= 16'h0;
			fire <= '{stb: 1'b0, blk: 3'h0, chan: 4'h0, ofs_ns: 32'sh0};
		end else begin
			seq_act <= next_seq_act;
			seq_blk <= next_seq_blk;
			seq_ch <= next_seq_ch;
			seq_ns <= next_seq_ns;
			fire <= next_fire;
		end
	end

endmodule

// [pkg/ats_pkg.sv]
// Shared constants, types and register map of the absolute time block.
// Assumes a 100 MHz APB clock and a seconds count whose zero is the virtual start time.
package ats_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SEC = 8'h08;
	localparam logic [7:0] OFS_USEC = 8'h0c;
	localparam logic [7:0] OFS_PKT_SEC = 8'h10;
	localparam logic [7:0] OFS_PKT_USEC = 8'h14;

	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam int ST_NMEA_LSB = 0;
	localparam int ST_PPS_LSB = 2;
	localparam int ST_PTP_LSB = 4;
	localparam int ST_SYNC_BIT = 6;
	localparam int ST_TICK_BIT = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_NS = 10;
	localparam int SEC_NS = 1_000_000_000;
	localparam int US_NS = 1000;
	localparam int TICK_CYC_DEF = SEC_NS / CLK_NS;
	localparam int CYC_PER_US = US_NS / CLK_NS;
	localparam int PPS_LOSS_NS = 1_500_000_000;
	localparam int PPS_LOSS_CYC_DEF = PPS_LOSS_NS / CLK_NS;
	localparam int NMEA_LOSS_NS = 2_000_000_000;
	localparam int NMEA_LOSS_CYC_DEF = NMEA_LOSS_NS / CLK_NS;
	localparam logic [19:0] USEC_MAX = 20'hf423f;
	localparam logic [31:0] EPOCH_SEC = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Block and channel firing offsets in ns
	localparam logic signed [31:0] BLK_BASE_NS = 32'sh0000_1600;
	localparam logic signed [31:0] BLK_STEP_NS = 32'sh0000_c350;
	localparam logic [15:0] CH_STEP_NS = 16'h0bd0;
	localparam logic [15:0] CH_BASE_NS = 16'h0170;
	localparam logic [2:0] BLK_LAST = 3'h7;
	localparam logic [3:0] CH_LAST = 4'hf;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {LK_UNLOCKED, LK_LOCKED, LK_LOST} ats_lock_e;
	typedef enum logic [1:0] {PTP_FREE_RUN, PTP_TRACKING, PTP_LOCKED, PTP_FROZEN} ats_ptp_e;

	typedef struct packed {
		logic dual_return;
		logic pulse_lock_gate;
		logic sentence_gga;
		logic src_ptp;
	} ats_ctrl_s;

	typedef struct packed {
		logic stb;
		logic fix;
		logic gga;
		logic [31:0] sec;
	} ats_nmea_s;

	typedef struct packed {
		ats_ptp_e state;
		logic load;
		logic [31:0] sec;
		logic [19:0] usec;
	} ats_ptp_s;

	typedef struct packed {
		logic [31:0] sec;
		logic [19:0] usec;
	} ats_time_s;

	typedef struct packed {
		logic stb;
		logic [2:0] blk;
		logic [3:0] chan;
		logic signed [31:0] ofs_ns;
	} ats_fire_s;

endpackage

// [dv/ats_gps_model.sv]
// GPS receiver model: a pulse each period, a time sentence after it.
// Assumes the bench enables both and picks the sentence type.
`timescale 1ns/1ps
module ats_gps_model #(parameter int PERIOD = 190, parameter int LAG = 50) (
	input wire logic pclk,
	input wire logic pps_en,
	input wire logic nmea_en,
	input wire logic gga,
	output logic pps_in,
	output ats_pkg::ats_nmea_s nmea
);
	import ats_pkg::*;
	int cnt = 0;
	logic [31:0] gsec = 32'h1000;
	initial begin
		pps_in = 1'b0;
		nmea = '0;
	end
	always @(posedge pclk) begin
		cnt <= cnt == PERIOD - 1 ? 0 : cnt + 1;
		gsec <= gsec + {31'h0, cnt == PERIOD - 1};
		pps_in <= pps_en && cnt < 10;
		nmea.stb <= nmea_en && cnt == LAG;
		nmea.fix <= 1'b1;
		nmea.gga <= gga;
		nmea.sec <= nmea_en && cnt == LAG ? gsec : ~nmea.sec;
	end
endmodule

// [dv/ats_top_chk.sv]
// Checker for ats_top: tick, packet, capture and firing relations.
// Bound to ats_top; sees its ports only.
`timescale 1ns/1ps
module ats_top_chk #(parameter int TICK_CYC = 200) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pps_in,
	input wire logic pkt_mark,
	input wire logic tick_pulse,
	input wire logic gps_pkt_stb,
	input wire ats_pkg::ats_time_s time_now,
	input wire ats_pkg::ats_time_s packet_abs_time,
	input wire ats_pkg::ats_ptp_s ptp,
	input wire ats_pkg::ats_fire_s fire
);
	import ats_pkg::*;
	logic [31:0] gap, next_gap;
	logic seen, next_seen;
	ats_fire_s last, next_last;
	always_comb begin
		next_gap = (tick_pulse || ptp.load) ? 32'h0 : gap + 32'h1;
		next_seen = seen | pps_in;
		next_last = fire.stb ? fire : last;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 32'h0;
			seen <= 1'b0;
			last <= '0;
		end else begin
			gap <= next_gap;
			seen <= next_seen;
			last <= next_last;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pkt_on_tick: assert property (gps_pkt_stb |-> tick_pulse)
		else $error("packet without tick");
	a_tick_usec: assert property (tick_pulse |-> ##[0:1] time_now.usec == 20'h0)
		else $error("usec not cleared");
	a_tick_due: assert property (gap <= TICK_CYC + 1)
		else $error("tick missing");
	a_pps_align: assert property ($rose(pps_in) && seen |-> ##[1:2] tick_pulse)
		else $error("tick not aligned");
	a_fire_order: assert property (fire.stb && fire.chan != 4'h0 |->
		fire.chan == last.chan + 4'h1 && fire.blk == last.blk)
		else $error("channel order");
	a_fire_step: assert property (fire.stb && fire.chan != 4'h0 |->
		fire.ofs_ns - last.ofs_ns == 3024)
		else $error("channel step");
	a_block_start: assert property (fire.stb && fire.chan == 4'h0 |->
		fire.ofs_ns == 6000 - 50000 * (7 - int'(fire.blk)) ||
		fire.ofs_ns == 6000 - 50000 * ((7 - int'(fire.blk)) / 2))
		else $error("block start");
	a_pkt_capture: assert property (pkt_mark |=> packet_abs_time == $past(time_now))
		else $error("capture");
	c_gps_pkt: cover property (gps_pkt_stb);
	c_last_chan: cover property (fire.stb && fire.chan == 4'hf);
	c_capture: cover property (pkt_mark);
endmodule
bind ats_top ats_top_chk #(.TICK_CYC(TICK_CYC)) u_chk (.pclk, .presetn, .pps_in, .pkt_mark,
	.tick_pulse, .gps_pkt_stb, .time_now, .packet_abs_time, .ptp, .fire);

// [dv/test_absolute_time_sync.sv]
// Bench for ats_top with a GPS model: free run, gating, PTP, lock and firing.
// Assumes shortened tick and loss counts.
`timescale 1ns/1ps
module test_absolute_time_sync;
	import ats_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pkt_mark = 1'b0, round_go = 1'b0, pps_en = 1'b0, nmea_en = 1'b0, gga = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [2:0] round_blk = 3'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, s, seed = 32'h7db2, last_sec = 32'h0;
	logic pready, pslverr, pps_in, tick_pulse, gps_pkt_stb, err;
	ats_nmea_s nmea;
	ats_ptp_s ptp = '0;
	ats_time_s time_now, packet_abs_time;
	ats_fire_s fire;
	int pkts = 0, p, error_cnt = 0, checked = 0;
	ats_top #(.TICK_CYC(200), .PPS_LOSS_CYC(300), .NMEA_LOSS_CYC(400)) u_dut (.pclk, .presetn,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .pps_in, .nmea,
		.ptp, .pkt_mark, .round_go, .round_blk, .tick_pulse, .gps_pkt_stb, .time_now,
		.packet_abs_time, .fire);
	ats_gps_model u_gps (.pclk, .pps_en, .nmea_en, .gga, .pps_in, .nmea);
	initial begin
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (gps_pkt_stb === 1'b1)
			pkts <= pkts + 1;
		if (nmea.stb === 1'b1)
			last_sec <= nmea.sec;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] exp_ofs(input logic [2:0] b, input logic d, input int c);
		int n;
		n = 7 - int'(b);
		if (d)
			n = n / 2;
		return 32'(5632 - 50000 * n + 3024 * c + 368);
	endfunction
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("Error %0t: %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge tick_pulse);
		repeat (2) @(negedge pclk);
	endtask
	task automatic wrap_up();
		$display("Errors %0d, checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd === 32'h0, "control reset");
		apb(1'b1, 8'h40, rnd());
		chk(err === 1'b1, "unmapped");
		tk(1);
		chk(time_now === {32'h1, 20'h0}, "first second");
		tk(1);
		apb(1'b0, OFS_SEC, 32'h0);
		chk(rd === 32'h2, "free count");
		apb(1'b1, OFS_CTRL, 32'h4);
		nmea_en <= 1'b1;
		tk(2);
		s = time_now.sec;
		tk(1);
		chk(time_now.sec === s + 1, "gated");
		@(posedge pclk);
		nmea_en <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h1);
		tk(1);
		p = pkts;
		s = time_now.sec;
		@(posedge pclk);
		ptp.sec <= rnd();
		ptp.load <= 1'b1;
		@(posedge pclk);
		ptp.load <= 1'b0;
		tk(1);
		chk(pkts === p && time_now.sec === s + 1, "free run");
		for (int i = 1; i < 3; i++) begin
			@(posedge pclk);
			ptp.state <= ats_ptp_e'(i);
			ptp.sec <= rnd();
			ptp.usec <= {19'h0, seed[0]};
			ptp.load <= 1'b1;
			@(posedge pclk);
			ptp.load <= 1'b0;
			repeat (2) @(negedge pclk);
			chk(time_now === {ptp.sec, ptp.usec}, "master load");
		end
		@(posedge pclk);
		ptp.state <= PTP_FROZEN;
		s = time_now.sec;
		tk(1);
		chk(time_now.sec === s + 1, "frozen");
		@(posedge pclk);
		presetn <= 1'b0;
		ptp <= '0;
		@(posedge pclk);
		presetn <= 1'b1;
		pps_en <= 1'b1;
		gga <= 1'b1;
		nmea_en <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			apb(1'b1, OFS_CTRL, {30'h0, t[0], 1'b0});
			gga <= !t[0];
			repeat (450) @(posedge pclk);
			tk(1);
			s = time_now.sec;
			tk(1);
			chk(time_now.sec === s + 1, "wrong type");
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(rd[1:0] === {t[0], 1'b0} && rd[3:2] === 2'h1, "lock status");
			@(posedge pclk);
			gga <= t[0];
			tk(2);
			p = pkts;
			tk(1);
			chk(time_now.sec === last_sec + 1 && pkts === p + 1, "locked");
		end
		@(posedge pclk);
		nmea_en <= 1'b0;
		repeat (450) @(posedge pclk);
		tk(1);
		s = time_now.sec;
		tk(1);
		chk(time_now.sec === s + 1, "drift");
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, OFS_CTRL, {28'h0, k[0], 3'h0});
			s = rnd();
			round_blk <= k < 2 ? {3{k[0]}} : s[2:0];
			round_go <= 1'b1;
			pkt_mark <= 1'b1;
			@(posedge pclk);
			round_go <= 1'b0;
			pkt_mark <= 1'b0;
			for (int c = 0; c < 16; c++) begin
				do @(posedge pclk); while (fire.stb !== 1'b1);
				s = exp_ofs(round_blk, k[0], c);
				chk(fire.chan === c[3:0] && fire.ofs_ns === s, "firing");
				chk(fire.blk === round_blk, "firing block");
			end
		end
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		wrap_up();
	end
endmodule
